// *** design/video_pkg.sv ***
// shared constants for the video memory display path
package video_pkg;
  // ==================== clocks ====================
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned DOT_HZ = 14112000;
  localparam int unsigned DOTS_PER_CHAR = 8;
  localparam int unsigned ACC_W = 28;
  // ==================== vram slots ====================
  localparam int unsigned SLOTS_PER_ROUND = 3;
  localparam logic [1:0] CPU_SLOT = 2'h2;
  localparam logic [1:0] PH_ROW = 2'h0;
  localparam logic [1:0] PH_COL = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  localparam logic [1:0] PH_PRE = 2'h3;
  // ==================== cpu memory window ====================
  localparam logic [23:0] WINDOW_BASE = 24'h0ba000;
  localparam logic [23:0] BANK_SPAN = 24'h010000;
  localparam logic [23:0] WINDOW_SIZE = 24'h030000;
  localparam logic [1:0] BANK_RED = 2'h0;
  localparam logic [1:0] BANK_GREEN = 2'h1;
  localparam logic [1:0] BANK_BLUE = 2'h2;
  // ==================== io ports (port number on address bits a2-a9) ====================
  localparam logic [7:0] PORT_CONTROL = 8'hd8;
  localparam logic [7:0] PORT_MAP = 8'hd9;
  localparam logic [7:0] PORT_STATUS = 8'hda;
  localparam logic [7:0] PORT_DC_INDEX = 8'hdc;
  localparam logic [7:0] PORT_DC_DATA = 8'hdd;
  localparam int unsigned PORT_LSB = 2;
  // control port fields
  localparam int unsigned CTL_EN_LSB = 0;
  localparam int unsigned CTL_FLASH = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h07;
  // display controller register indexes
  localparam logic [2:0] DC_H_TOTAL = 3'h0;
  localparam logic [2:0] DC_H_DISP = 3'h1;
  localparam logic [2:0] DC_V_TOTAL = 3'h2;
  localparam logic [2:0] DC_V_DISP = 3'h3;
  localparam logic [2:0] DC_START_HI = 3'h4;
  localparam logic [2:0] DC_START_LO = 3'h5;
  localparam logic [2:0] DC_CURSOR_HI = 3'h6;
  localparam logic [2:0] DC_CURSOR_LO = 3'h7;
  localparam logic [7:0] H_TOTAL_RESET = 8'h63;
  localparam logic [7:0] H_DISP_RESET = 8'h50;
  localparam logic [7:0] V_TOTAL_RESET = 8'hff;
  localparam logic [7:0] V_DISP_RESET = 8'he0;
  localparam logic [7:0] HSYNC_GAP = 8'h04;
  localparam logic [7:0] HSYNC_W = 8'h08;
  localparam logic [7:0] VSYNC_GAP = 8'h04;
  localparam logic [7:0] VSYNC_W = 8'h03;
  // ==================== axi answers ====================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // composite output levels
  localparam logic [1:0] COMP_SYNC = 2'h0;
  localparam logic [1:0] COMP_BLACK = 2'h1;
  localparam logic [1:0] COMP_WHITE = 2'h2;
endpackage

// *** design/dot_serializer.sv ***
// parallel to serial converter for one colour plane
`timescale 1ns/1ps
`default_nettype none
module dot_serializer #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strobes
  input wire logic load,
  input wire logic shift,
  // data
  input wire logic [WIDTH-1:0] byte_in,
  output logic dot
);
  logic [WIDTH-1:0] shreg;

  // ==================== shift register ====================
  // load wins over shift so a character boundary never loses a dot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg <= '0;
    end else if (load) begin
      shreg <= byte_in;
    end else if (shift) begin
      shreg <= {shreg[WIDTH-2:0], 1'b0};
    end
  end

  assign dot = shreg[WIDTH-1];
endmodule
`default_nettype wire

// *** design/video_display_path.sv ***
// video board display path: vram arbitration, fetch, serialising and io ports
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module video_display_path #(
  parameter bit COLOUR_BUILD = 1'b1,
  parameter int unsigned ADDR_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite io port access
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu memory window
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_done,
  output logic rdy,
  // video ram
  output logic [7:0] vram_mux_address,
  output logic row_col_select,
  output logic cpu_mux_select,
  output logic ras_n,
  output logic cas_n,
  output logic [2:0] bank_we_n,
  output logic [7:0] vram_wdata,
  input wire logic [7:0] vram_red,
  input wire logic [7:0] vram_green,
  input wire logic [7:0] vram_blue,
  // monitor outputs
  output logic red,
  output logic green,
  output logic blue,
  output logic hsync,
  output logic vsync,
  output logic [1:0] composite
);
  typedef enum logic [1:0] {OWN_IDLE, OWN_DISP, OWN_CPU} owner_e;

  // ==================== dot and character timing ====================
  logic [video_pkg::ACC_W-1:0] acc;
  logic [video_pkg::ACC_W-1:0] next_acc;
  logic dot_tick;
  logic [2:0] dot_cnt;
  logic char_tick;

  always_comb begin
    next_acc = acc + video_pkg::ACC_W'(video_pkg::DOT_HZ);
    if (next_acc >= video_pkg::ACC_W'(video_pkg::CLK_HZ)) begin
      next_acc = next_acc - video_pkg::ACC_W'(video_pkg::CLK_HZ);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      dot_tick <= 1'b0;
    end else begin
      acc <= next_acc;
      dot_tick <= (acc + video_pkg::ACC_W'(video_pkg::DOT_HZ))
                  >= video_pkg::ACC_W'(video_pkg::CLK_HZ);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dot_cnt <= '0;
    end else if (dot_tick) begin
      dot_cnt <= dot_cnt + 3'h1;
    end
  end
  assign char_tick = dot_tick && (dot_cnt == 3'(video_pkg::DOTS_PER_CHAR - 1));

  // ==================== io port registers ====================
  logic [7:0] control;
  logic [7:0] map_pattern;
  logic [2:0] dc_index;
  logic [7:0] h_total, h_disp, v_total, v_disp;
  logic [ADDR_W-1:0] start_addr, cursor_addr;
  logic [7:0] aw_port, ar_port;
  logic aw_held, w_held;
  logic [7:0] w_byte;
  logic w_lane;
  logic do_write;
  logic [7:0] rd_byte;
  logic rd_hit, wr_hit;
  logic vblank_now;

  function automatic logic port_known(input logic [7:0] p);
    port_known = (p == video_pkg::PORT_CONTROL) || (p == video_pkg::PORT_MAP)
              || (p == video_pkg::PORT_STATUS) || (p == video_pkg::PORT_DC_INDEX)
              || (p == video_pkg::PORT_DC_DATA);
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = port_known(aw_port) && (aw_port != video_pkg::PORT_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_port <= '0;
      w_byte <= '0;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= video_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_port <= s_axi_awaddr[video_pkg::PORT_LSB +: 8];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? video_pkg::RESP_OKAY : video_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control port holds enables and flash
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= video_pkg::CONTROL_RESET;
      map_pattern <= '0;
      dc_index <= '0;
    end else if (do_write && w_lane) begin
      if (aw_port == video_pkg::PORT_CONTROL) control <= w_byte;
      if (aw_port == video_pkg::PORT_MAP) map_pattern <= w_byte;
      if (aw_port == video_pkg::PORT_DC_INDEX) dc_index <= w_byte[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_total <= video_pkg::H_TOTAL_RESET;
      h_disp <= video_pkg::H_DISP_RESET;
      v_total <= video_pkg::V_TOTAL_RESET;
      v_disp <= video_pkg::V_DISP_RESET;
      start_addr <= '0;
      cursor_addr <= '0;
    end else if (do_write && w_lane && aw_port == video_pkg::PORT_DC_DATA) begin
      case (dc_index)
        video_pkg::DC_H_TOTAL: h_total <= w_byte;
        video_pkg::DC_H_DISP: h_disp <= w_byte;
        video_pkg::DC_V_TOTAL: v_total <= w_byte;
        video_pkg::DC_V_DISP: v_disp <= w_byte;
        video_pkg::DC_START_HI: start_addr[ADDR_W-1:8] <= w_byte[ADDR_W-9:0];
        video_pkg::DC_START_LO: start_addr[7:0] <= w_byte;
        video_pkg::DC_CURSOR_HI: cursor_addr[ADDR_W-1:8] <= w_byte[ADDR_W-9:0];
        default: cursor_addr[7:0] <= w_byte;
      endcase
    end
  end

  // of the display controller registers only start and cursor read back
  always_comb begin
    rd_byte = '0;
    rd_hit = port_known(ar_port);
    case (ar_port)
      video_pkg::PORT_CONTROL: rd_byte = control;
      video_pkg::PORT_MAP: rd_byte = map_pattern;
      video_pkg::PORT_STATUS: rd_byte = {6'h00, vblank_now, control[video_pkg::CTL_FLASH]};
      video_pkg::PORT_DC_INDEX: rd_byte = {5'h00, dc_index};
      video_pkg::PORT_DC_DATA: begin
        case (dc_index)
          video_pkg::DC_START_HI: rd_byte = 8'(start_addr[ADDR_W-1:8]);
          video_pkg::DC_START_LO: rd_byte = start_addr[7:0];
          video_pkg::DC_CURSOR_HI: rd_byte = 8'(cursor_addr[ADDR_W-1:8]);
          video_pkg::DC_CURSOR_LO: rd_byte = cursor_addr[7:0];
          default: rd_byte = '0;
        endcase
      end
      default: rd_byte = '0;
    endcase
  end

  assign ar_port = s_axi_araddr[video_pkg::PORT_LSB +: 8];
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= video_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? video_pkg::RESP_OKAY : video_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==================== raster and fetch ====================
  logic [7:0] hcount, vcount;
  logic [ADDR_W-1:0] scan_addr, fetch_addr;
  logic fetch_pending;
  logic active_now, hs_now, vs_now;
  logic [2:0] ctl_stage, ctl_aligned;
  logic cursor_stage, cursor_aligned;
  logic [7:0] fetch_data [3];
  logic fetch_valid;

  assign active_now = (hcount < h_disp) && (vcount < v_disp);
  assign vblank_now = (vcount >= v_disp);
  assign hs_now = (hcount >= h_disp + video_pkg::HSYNC_GAP)
               && (hcount < h_disp + video_pkg::HSYNC_GAP + video_pkg::HSYNC_W);
  assign vs_now = (vcount >= v_disp + video_pkg::VSYNC_GAP)
               && (vcount < v_disp + video_pkg::VSYNC_GAP + video_pkg::VSYNC_W);

  // sequential fetch, reload at frame end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcount <= '0;
      vcount <= '0;
      scan_addr <= '0;
    end else if (char_tick) begin
      hcount <= (hcount >= h_total) ? 8'h00 : hcount + 8'h01;
      if (hcount >= h_total) begin
        vcount <= (vcount >= v_total) ? 8'h00 : vcount + 8'h01;
      end
      if (hcount >= h_total && vcount >= v_total) begin
        scan_addr <= start_addr;
      end else if (active_now) begin
        scan_addr <= scan_addr + 1'b1;
      end
    end
  end

  // attributes delayed two characters, matching the fetch latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_stage <= '0;
      ctl_aligned <= '0;
      cursor_stage <= 1'b0;
      cursor_aligned <= 1'b0;
    end else if (char_tick) begin
      ctl_stage <= {!active_now, hs_now, vs_now};
      cursor_stage <= active_now && (scan_addr == cursor_addr);
      ctl_aligned <= ctl_stage;
      cursor_aligned <= cursor_stage;
    end
  end

  // ==================== vram slot sequencer ====================
  logic [1:0] phase, slot;
  owner_e owner;
  owner_e next_owner;
  logic cpu_pending, cpu_in_window;
  logic [23:0] cpu_offset;
  logic [1:0] cpu_bank;
  logic [ADDR_W-1:0] cpu_mapped, full_addr;

  // window decode between 744K and 936K
  assign cpu_offset = mem_addr - video_pkg::WINDOW_BASE;
  assign cpu_in_window = (mem_addr >= video_pkg::WINDOW_BASE)
                      && (cpu_offset < video_pkg::WINDOW_SIZE);
  assign cpu_bank = 2'(cpu_offset / video_pkg::BANK_SPAN);
  // pattern folds onto a4-a6 and a11-a15, rest passes through
  always_comb begin
    cpu_mapped = cpu_offset[ADDR_W-1:0];
    cpu_mapped[6:4] = cpu_offset[6:4] ^ map_pattern[2:0];
    cpu_mapped[15:11] = cpu_offset[15:11] ^ map_pattern[7:3];
  end
  assign cpu_pending = mem_req && cpu_in_window && !mem_done;

  // two display slots then one cpu slot
  always_comb begin
    next_owner = OWN_IDLE;
    if (slot == video_pkg::CPU_SLOT) begin
      if (cpu_pending) next_owner = OWN_CPU;
    end else if (fetch_pending) begin
      next_owner = OWN_DISP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= video_pkg::PH_ROW;
      slot <= '0;
      owner <= OWN_IDLE;
    end else begin
      phase <= phase + 2'h1;
      if (phase == video_pkg::PH_PRE) begin
        slot <= (slot == 2'(video_pkg::SLOTS_PER_ROUND - 1)) ? 2'h0 : slot + 2'h1;
        owner <= next_owner;
      end
    end
  end

  // display address unless the cpu owns the slot
  assign full_addr = (owner == OWN_CPU) ? cpu_mapped : fetch_addr;

  // row is low byte, column high byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vram_mux_address <= '0;
      row_col_select <= 1'b0;
      cpu_mux_select <= 1'b0;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      bank_we_n <= 3'h7;
      vram_wdata <= '0;
    end else begin
      cpu_mux_select <= (owner == OWN_CPU);
      row_col_select <= (phase == video_pkg::PH_ROW);
      vram_mux_address <= (phase == video_pkg::PH_ROW) ? full_addr[7:0] : full_addr[15:8];
      ras_n <= !(owner != OWN_IDLE && phase != video_pkg::PH_PRE);
      cas_n <= !(owner != OWN_IDLE && (phase == video_pkg::PH_COL || phase == video_pkg::PH_DATA));
      vram_wdata <= mem_wdata;
      bank_we_n <= 3'h7;
      // display never writes; mono builds write green only
      if (owner == OWN_CPU && mem_write && phase == video_pkg::PH_COL
          && (COLOUR_BUILD || cpu_bank == video_pkg::BANK_GREEN)) begin
        bank_we_n[cpu_bank] <= 1'b0;
      end
    end
  end

  // all three planes captured together on a display slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_pending <= 1'b0;
      fetch_addr <= '0;
      fetch_valid <= 1'b0;
      fetch_data[0] <= '0;
      fetch_data[1] <= '0;
      fetch_data[2] <= '0;
    end else begin
      if (char_tick) begin
        fetch_pending <= active_now;
        fetch_addr <= scan_addr;
        fetch_valid <= 1'b0;
      end else if (owner == OWN_DISP && phase == video_pkg::PH_DATA) begin
        fetch_pending <= 1'b0;
        fetch_valid <= 1'b1;
        fetch_data[video_pkg::BANK_RED] <= COLOUR_BUILD ? vram_red : 8'h00;
        fetch_data[video_pkg::BANK_GREEN] <= vram_green;
        fetch_data[video_pkg::BANK_BLUE] <= COLOUR_BUILD ? vram_blue : 8'h00;
      end
    end
  end

  // ==================== cpu data-in latches ====================
  // latch only on a cpu slot, one colour group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rdata <= '0;
      mem_done <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      if (owner == OWN_CPU && phase == video_pkg::PH_DATA) begin
        mem_done <= 1'b1;
        if (!mem_write) begin
          case (cpu_bank)
            video_pkg::BANK_RED: mem_rdata <= COLOUR_BUILD ? vram_red : 8'h00;
            video_pkg::BANK_GREEN: mem_rdata <= vram_green;
            default: mem_rdata <= COLOUR_BUILD ? vram_blue : 8'h00;
          endcase
        end
      end
    end
  end

  // cpu waits while its access is not yet served
  assign rdy = !cpu_pending;

  // ==================== serialisers and video processing ====================
  logic [2:0] dots;
  logic [2:0] enables;
  logic [2:0] colour_q;
  logic flash;

  assign enables = control[video_pkg::CTL_EN_LSB +: 3];
  assign flash = control[video_pkg::CTL_FLASH];

  // one converter per colour, loaded each character
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_plane
      dot_serializer #(.WIDTH(8)) u_ser (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(char_tick),
        .shift(dot_tick),
        .byte_in(fetch_valid ? fetch_data[gi] : 8'h00),
        .dot(dots[gi])
      );
      // enable gates dots, flash forces enabled primaries
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          colour_q[gi] <= 1'b0;
        end else begin
          colour_q[gi] <= enables[gi] && !ctl_aligned[2]
                          && (flash || dots[gi] || cursor_aligned);
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hsync <= 1'b0;
      vsync <= 1'b0;
      composite <= video_pkg::COMP_BLACK;
    end else begin
      hsync <= ctl_aligned[1];
      vsync <= ctl_aligned[0];
      if (ctl_aligned[1] || ctl_aligned[0]) begin
        composite <= video_pkg::COMP_SYNC;
      end else if (|colour_q) begin
        composite <= video_pkg::COMP_WHITE;
      end else begin
        composite <= video_pkg::COMP_BLACK;
      end
    end
  end

  assign red = colour_q[video_pkg::BANK_RED];
  assign green = colour_q[video_pkg::BANK_GREEN];
  assign blue = colour_q[video_pkg::BANK_BLUE];
endmodule
`default_nettype wire

// *** bench/video_display_path_properties.sv ***
// port timing checker for the video display path
`timescale 1ns/1ps
`default_nettype none
module video_display_path_properties #(
  parameter bit COLOUR_BUILD = 1'b1,
  parameter int unsigned ADDR_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cpu window and vram
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic mem_done,
  input wire logic rdy,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic cpu_mux_select,
  input wire logic [2:0] bank_we_n,
  // port bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_arready
);
  // ==================== properties ====================
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic in_win = mem_addr >= video_pkg::WINDOW_BASE &&
    mem_addr < video_pkg::WINDOW_BASE + video_pkg::WINDOW_SIZE;
  // row half first, column half one phase later
  sequence s_strobe;
    !ras_n ##1 (!ras_n && !cas_n);
  endsequence
  property p_rdy_stall;
    mem_req && in_win && !mem_done |-> !rdy;
  endproperty
  a_rdy_stall: assert property (p_rdy_stall) else $error("rdy high while access pending");
  property p_done_bound;
    $rose(mem_req) && in_win |-> ##[1:16] mem_done;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("cpu access never served");
  property p_out_win;
    mem_req && !in_win |-> rdy && !mem_done;
  endproperty
  a_out_win: assert property (p_out_win) else $error("outside window answered");
  property p_strobe;
    $fell(ras_n) |-> s_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("column strobe not after row");
  property p_we_cpu;
    bank_we_n != 3'h7 |-> cpu_mux_select && $onehot(~bank_we_n);
  endproperty
  a_we_cpu: assert property (p_we_cpu) else $error("write outside cpu slot");
  property p_cpu_slot;
    $fell(cpu_mux_select) |-> !cpu_mux_select [*8];
  endproperty
  a_cpu_slot: assert property (p_cpu_slot) else $error("display lost its two slots");
  property p_bvalid_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bvalid_once: assert property (p_bvalid_once) else $error("write answer repeated");
  property p_rdata_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte) else $error("read answer malformed");
endmodule
bind video_display_path video_display_path_properties #(.COLOUR_BUILD(COLOUR_BUILD),
  .ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .mem_req, .mem_addr, .mem_done, .rdy,
  .ras_n, .cas_n, .cpu_mux_select, .bank_we_n, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_arready);
`default_nettype wire

// *** bench/vram_model.sv ***
// behavioural three-bank video ram
`timescale 1ns/1ps
`default_nettype none
module vram_model (
  // strobes and address
  input wire logic aclk,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic [2:0] bank_we_n,
  input wire logic [7:0] vram_mux_address,
  input wire logic [7:0] vram_wdata,
  // read buses
  output logic [7:0] vram_red,
  output logic [7:0] vram_green,
  output logic [7:0] vram_blue
);
  // ==================== storage ====================
  logic [7:0] mem [3][65536];
  logic [7:0] last [3];
  logic [7:0] row = 8'h00;
  wire logic [15:0] addr = {vram_mux_address, row};
  // blue starts dark so only flash, the cursor or a cpu write to the blue bank can light it
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[0][i] = 8'hff;
      mem[1][i] = 8'hff;
      mem[2][i] = 8'h00;
    end
  end
  // one bank per colour, all read at once
  always @(posedge aclk) begin
    if (!ras_n && cas_n)
      row <= vram_mux_address;
    for (int b = 0; b < 3; b++) begin
      if (!bank_we_n[b])
        mem[b][addr] <= vram_wdata;
      if (!cas_n)
        last[b] <= mem[b][addr];
    end
  end
  // released bus shows the inverse, never a held value
  assign vram_red = !cas_n ? mem[0][addr] : ~last[0];
  assign vram_green = !cas_n ? mem[1][addr] : ~last[1];
  assign vram_blue = !cas_n ? mem[2][addr] : ~last[2];
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the video display path
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==================== signals ====================
  logic aclk = 1'b0, aresetn = 1'b0, mem_req = 1'b0, mem_write = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [23:0] mem_addr = 24'h0;
  logic [7:0] mem_wdata = 8'h0, mem_rdata, vram_mux_address, vram_wdata;
  logic [7:0] vram_red, vram_green, vram_blue;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_done, rdy, row_col_select, cpu_mux_select, ras_n, cas_n;
  logic red, green, blue, hsync, vsync;
  logic [1:0] s_axi_bresp, s_axi_rresp, composite;
  logic [2:0] bank_we_n;
  int errors = 0, samples_checked = 0, cyc = 0;
  always #4 aclk = ~aclk;
  video_display_path DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_done, .rdy, .vram_mux_address, .row_col_select, .cpu_mux_select, .ras_n, .cas_n,
    .bank_we_n, .vram_wdata, .vram_red, .vram_green, .vram_blue, .red, .green, .blue,
    .hsync, .vsync, .composite);
  vram_model vram (.aclk, .ras_n, .cas_n, .bank_we_n, .vram_mux_address, .vram_wdata,
    .vram_red, .vram_green, .vram_blue);
  // ==================== tasks ====================
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] p, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, p, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] p, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, p, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    chk("rdata", s_axi_rdata, {24'h0, d});
  endtask
  task automatic mem_acc(input logic w, input logic [23:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge aclk);
    mem_req <= 1'b1;
    mem_write <= w;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge aclk);
    chk("rdy", 32'(rdy), 32'h0);
    while (!mem_done) @(posedge aclk);
    q = mem_rdata;
    mem_req <= 1'b0;
  endtask
  // ==================== scenarios ====================
  task automatic t_ports();
    axi_rd(video_pkg::PORT_CONTROL, video_pkg::CONTROL_RESET, 2'h0);
    axi_wr(video_pkg::PORT_CONTROL, 8'h0d, 2'h0);
    axi_rd(video_pkg::PORT_CONTROL, 8'h0d, 2'h0);
    axi_wr(8'h00, 8'h55, video_pkg::RESP_SLVERR);
    axi_wr(video_pkg::PORT_STATUS, 8'h01, video_pkg::RESP_SLVERR);
    axi_wr(video_pkg::PORT_DC_INDEX, 8'h07, 2'h0);
    axi_wr(video_pkg::PORT_DC_DATA, 8'h5a, 2'h0);
    axi_rd(video_pkg::PORT_DC_DATA, 8'h5a, 2'h0);
    axi_wr(video_pkg::PORT_DC_INDEX, 8'h01, 2'h0);
    axi_rd(video_pkg::PORT_DC_DATA, 8'h00, 2'h0);
  endtask
  task automatic t_mem();
    logic [7:0] q;
    logic [23:0] a;
    for (int b = 0; b < 3; b++) begin
      a = video_pkg::WINDOW_BASE + video_pkg::BANK_SPAN * b + 24'h0123;
      mem_acc(1'b1, a, 8'h30 + 8'(b), q);
      mem_acc(1'b0, a, 8'h00, q);
      chk("cpu read", 32'(q), 32'h30 + b);
      chk("bank cell", 32'(vram.mem[b][16'h0123]), 32'h30 + b);
    end
    axi_wr(video_pkg::PORT_MAP, 8'h09, 2'h0);
    mem_acc(1'b1, video_pkg::WINDOW_BASE + video_pkg::BANK_SPAN, 8'h77, q);
    chk("mapped cell", 32'(vram.mem[1][16'h0810]), 32'h77);
    axi_wr(video_pkg::PORT_MAP, 8'h00, 2'h0);
  endtask
  task automatic t_outwin();
    int n;
    n = 0;
    mem_req <= 1'b1;
    mem_addr <= 24'h0b0000;
    repeat (20) begin
      @(posedge aclk);
      n += int'(mem_done);
    end
    chk("stray done", 32'(n), 32'h0);
    chk("rdy kept", 32'(rdy), 32'h1);
    mem_req <= 1'b0;
  endtask
  // one line period is about 7100 cycles, so 9000 sees a full line
  task automatic t_video(input logic [7:0] ctl, input logic [2:0] msk, input logic [2:0] exp);
    logic [2:0] seen;
    logic [3:0] cm;
    logic hs;
    axi_wr(video_pkg::PORT_CONTROL, ctl, 2'h0);
    seen = 3'h0;
    cm = 4'h0;
    hs = 1'b0;
    repeat (9000) begin
      @(posedge aclk);
      seen |= {blue, green, red};
      cm |= 4'h1 << composite;
      hs |= hsync;
    end
    chk("colours", 32'(seen & msk), 32'(exp));
    chk("hsync", 32'(hs), 32'h1);
    chk("composite", 32'({cm[2], cm[0]}), 32'h3);
  endtask
  // ==================== run ====================
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    chk("idle composite", 32'(composite), 32'(video_pkg::COMP_BLACK));
    aresetn <= 1'b1;
    t_ports();
    t_mem();
    t_outwin();
    t_video(8'h06, 3'b011, 3'b010);
    t_video(8'h0c, 3'b111, 3'b100);
    complete_run();
  end
endmodule
`default_nettype wire
